/* rtl/adc_cfg_pkg.sv */
`default_nettype none
package adc_cfg_pkg;
    // ==========================================
    // register map (word addresses, byte addr / 4)
    localparam logic [1:0] CONFIG_IDX = 2'h0;
    localparam logic [1:0] RES_HIGH_IDX = 2'h1;
    localparam logic [1:0] RES_LOW_IDX = 2'h2;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // ==========================================
    // config field positions
    localparam int JUSTIFY_BIT = 7;
    localparam int CLKSEL_LSB = 4;
    localparam int PREF_LSB = 0;
    localparam logic [7:0] CONFIG_WMASK = 8'hf3;
    // ==========================================
    // clock divide ratios
    localparam logic [6:0] DIV2 = 7'h02;
    localparam logic [6:0] DIV4 = 7'h04;
    localparam logic [6:0] DIV8 = 7'h08;
    localparam logic [6:0] DIV16 = 7'h10;
    localparam logic [6:0] DIV32 = 7'h20;
    localparam logic [6:0] DIV64 = 7'h40;

    typedef enum logic [2:0] {
        CS_DIV2 = 3'h0, CS_DIV8 = 3'h1, CS_DIV32 = 3'h2, CS_RC = 3'h3,
        CS_DIV4 = 3'h4, CS_DIV16 = 3'h5, CS_DIV64 = 3'h6, CS_RC2 = 3'h7
    } clk_sel_t;

    typedef enum logic [1:0] {
        REF_SUPPLY = 2'h0, REF_RSVD = 2'h1, REF_EXT = 2'h2, REF_FIXED = 2'h3
    } pref_sel_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avl_req_t;

    typedef struct packed {
        logic valid;
        logic [9:0] value;
    } conv_result_t;

    typedef struct packed {
        logic use_rc;
        logic [6:0] div_ratio;
        logic ref_supply;
        logic ref_ext;
        logic ref_fixed;
    } conv_ctrl_t;
endpackage
`default_nettype wire

/* rtl/adc_config_result_format.sv */
// Overview of operation
// RL1: left justify zeroes low six result bits
// RL2: bits 6:4 pick conversion clock source
// RL3: config bits 3:2 read zero
// RL4: bits 1:0 pick positive reference
// RL5: left: result 9:2 into high register
// RL6: left: result 1:0 into low 7:6
// RL7: right: result 9:8 into high 1:0
// RL8: right: result 7:0 into low register
// RL9: software ignores high 7:2 when right
// RL10: result registers read/write, not reset
// RL11: bit 7 set means right justified
// RL12: code 110 div64, 111 rc
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
module adc_config_result_format (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire adc_cfg_pkg::avl_req_t avl_req_i,
    output logic avl_waitrequest_o,
    output logic [31:0] avl_readdata_o,
    input wire adc_cfg_pkg::conv_result_t conv_result_i,
    output adc_cfg_pkg::conv_ctrl_t conv_ctrl_o
);
    import adc_cfg_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================
    // bus slave
    // one wait cycle per access, so readdata is always a flop
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] config_reg, config_next;
    logic [7:0] result_high_reg, result_high_next;
    logic [7:0] result_low_reg, result_low_next;
    logic req;
    logic wr_hit;

    function automatic logic [1:0] word_index(input logic [3:0] addr);
        word_index = addr[3:2];
    endfunction

    assign req = avl_req_i.read | avl_req_i.write;
    assign avl_waitrequest_o = req & ~ack_reg;
    assign wr_hit = avl_req_i.write & ack_reg & avl_req_i.byteenable[0];
    assign avl_readdata_o = rdata_reg;

    always_comb begin
        ack_next = req & ~ack_reg;
        rdata_next = rdata_reg;
        if (avl_req_i.read & ~ack_reg) begin
            case (word_index(avl_req_i.address))
                CONFIG_IDX: rdata_next = {24'h000000, config_reg & CONFIG_WMASK}; // RL3
                RES_HIGH_IDX: rdata_next = {24'h000000, result_high_reg};
                RES_LOW_IDX: rdata_next = {24'h000000, result_low_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        config_next = config_reg;
        if (wr_hit && word_index(avl_req_i.address) == CONFIG_IDX) begin
            config_next = avl_req_i.writedata[7:0] & CONFIG_WMASK; // RL3
        end
    end

    // ==========================================
    // bus checks
    AST_RD_UPPER: assert property (
        1'b1
        |-> avl_readdata_o[31:8] == 24'h000000)
        else $error("readdata upper bits nonzero");

    AST_WAIT_FIRST: assert property (
        req && !ack_reg
        |-> avl_waitrequest_o)
        else $error("waitrequest missing on new request");

    AST_NO_REQ_NO_WAIT: assert property (
        !req
        |-> !avl_waitrequest_o)
        else $error("waitrequest without request");

    AST_ACK_PULSE: assert property (
        ack_reg
        |=> !ack_reg)
        else $error("acknowledge held too long");

    AST_CFG_WRITE: assert property ( // RL3
        wr_hit && word_index(avl_req_i.address) == CONFIG_IDX
        |=> config_reg == ($past(avl_req_i.writedata[7:0]) & CONFIG_WMASK))
        else $error("config write lost");

    AST_CFG_HOLD: assert property (
        !(wr_hit && word_index(avl_req_i.address) == CONFIG_IDX)
        |=> $stable(config_reg))
        else $error("config changed without write");

    AST_CFG_GAP: assert property ( // RL3
        1'b1
        |-> config_reg[3:2] == 2'h0)
        else $error("unimplemented config bits stored");

    AST_BE_IGNORED: assert property (
        avl_req_i.write && ack_reg && !avl_req_i.byteenable[0]
        |=> $stable(config_reg))
        else $error("write without byte enable landed");

    AST_RD_HIGH: assert property (
        avl_req_i.read && !ack_reg && word_index(avl_req_i.address) == RES_HIGH_IDX
        |=> avl_readdata_o == {24'h000000, $past(result_high_reg)})
        else $error("result high read mismatch");

    AST_RD_LOW: assert property (
        avl_req_i.read && !ack_reg && word_index(avl_req_i.address) == RES_LOW_IDX
        |=> avl_readdata_o == {24'h000000, $past(result_low_reg)})
        else $error("result low read mismatch");

    AST_RD_CFG: assert property ( // RL3
        avl_req_i.read && !ack_reg && word_index(avl_req_i.address) == CONFIG_IDX
        |=> avl_readdata_o[7:0] == ($past(config_reg) & CONFIG_WMASK))
        else $error("config read mismatch");

    AST_RD_UNMAPPED: assert property (
        avl_req_i.read && !ack_reg && word_index(avl_req_i.address) == 2'h3
        |=> avl_readdata_o == 32'h00000000)
        else $error("unmapped read nonzero");

    AST_RD_HOLD: assert property (
        !(avl_req_i.read && !ack_reg)
        |=> $stable(avl_readdata_o))
        else $error("readdata changed without read");

    // ==========================================
    // result formatting
    // a finished conversion outranks a software write in the same cycle
    always_comb begin
        result_high_next = result_high_reg;
        result_low_next = result_low_reg;
        if (wr_hit && word_index(avl_req_i.address) == RES_HIGH_IDX) begin
            result_high_next = avl_req_i.writedata[7:0]; // RL10
        end
        if (wr_hit && word_index(avl_req_i.address) == RES_LOW_IDX) begin
            result_low_next = avl_req_i.writedata[7:0]; // RL10
        end
        if (conv_result_i.valid) begin
            if (config_reg[JUSTIFY_BIT]) begin // RL11
                result_high_next = {6'h00, conv_result_i.value[9:8]}; // RL7 RL11
                result_low_next = conv_result_i.value[7:0]; // RL8
            end else begin
                result_high_next = conv_result_i.value[9:2]; // RL5
                result_low_next = {conv_result_i.value[1:0], 6'h00}; // RL6 RL1
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            config_reg <= CONFIG_RESET;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            config_reg <= config_next;
        end
    end

    // no reset: contents survive every reset
    always_ff @(posedge core_clk_i) begin
        result_high_reg <= result_high_next; // RL10
        result_low_reg <= result_low_next;
    end

    // ==========================================
    // result checks
    AST_RES_HIGH_WRITE: assert property ( // RL10
        wr_hit && word_index(avl_req_i.address) == RES_HIGH_IDX && !conv_result_i.valid
        |=> result_high_reg == $past(avl_req_i.writedata[7:0]))
        else $error("result high write lost");

    AST_LEFT_WHOLE: assert property ( // RL1
        conv_result_i.valid && !config_reg[JUSTIFY_BIT]
        |=> {result_high_reg, result_low_reg} == {$past(conv_result_i.value), 6'h00})
        else $error("left justified word mismatch");

    AST_RIGHT_WHOLE: assert property ( // RL11
        conv_result_i.valid && config_reg[JUSTIFY_BIT]
        |=> {result_high_reg, result_low_reg} == {6'h00, $past(conv_result_i.value)})
        else $error("right justified word mismatch");

    // ==========================================
    // clock and reference decode
    clk_sel_t clk_sel;
    pref_sel_t pref_sel;
    conv_ctrl_t ctrl_next, ctrl_reg;
    assign clk_sel = clk_sel_t'(config_reg[CLKSEL_LSB +: 3]);
    assign pref_sel = pref_sel_t'(config_reg[PREF_LSB +: 2]);

    always_comb begin
        ctrl_next = '0;
        case (clk_sel) // RL2 RL12
            CS_DIV2: ctrl_next.div_ratio = DIV2;
            CS_DIV8: ctrl_next.div_ratio = DIV8;
            CS_DIV32: ctrl_next.div_ratio = DIV32;
            CS_DIV4: ctrl_next.div_ratio = DIV4;
            CS_DIV16: ctrl_next.div_ratio = DIV16;
            CS_DIV64: ctrl_next.div_ratio = DIV64;
            default: ctrl_next.use_rc = 1'b1;
        endcase
        case (pref_sel) // RL4
            REF_EXT: ctrl_next.ref_ext = 1'b1;
            REF_FIXED: ctrl_next.ref_fixed = 1'b1;
            // reserved code falls back to the supply, the safe choice
            default: ctrl_next.ref_supply = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end
    assign conv_ctrl_o = ctrl_reg;

    // ==========================================
    // clock and reference checks
    AST_CLK_DIV2: assert property ( // RL2
        config_reg[6:4] == 3'h0
        |=> conv_ctrl_o.div_ratio == DIV2 && !conv_ctrl_o.use_rc)
        else $error("div2 not selected");

    AST_CLK_DIV8: assert property ( // RL2
        config_reg[6:4] == 3'h1
        |=> conv_ctrl_o.div_ratio == DIV8 && !conv_ctrl_o.use_rc)
        else $error("div8 not selected");

    AST_CLK_DIV32: assert property ( // RL2
        config_reg[6:4] == 3'h2
        |=> conv_ctrl_o.div_ratio == DIV32 && !conv_ctrl_o.use_rc)
        else $error("div32 not selected");

    AST_CLK_RC_LOW: assert property ( // RL2
        config_reg[6:4] == 3'h3
        |=> conv_ctrl_o.use_rc && conv_ctrl_o.div_ratio == 7'h00)
        else $error("rc clock code 3 not selected");

    AST_CLK_DIV4: assert property ( // RL2
        config_reg[6:4] == 3'h4
        |=> conv_ctrl_o.div_ratio == DIV4 && !conv_ctrl_o.use_rc)
        else $error("div4 not selected");

    AST_CLK_DIV16: assert property ( // RL2
        config_reg[6:4] == 3'h5
        |=> conv_ctrl_o.div_ratio == DIV16 && !conv_ctrl_o.use_rc)
        else $error("div16 not selected");

    AST_CLK_RC_HIGH: assert property ( // RL12
        config_reg[6:4] == 3'h7
        |=> conv_ctrl_o.use_rc && conv_ctrl_o.div_ratio == 7'h00)
        else $error("rc clock code 7 not selected");

    AST_REF_SUPPLY: assert property ( // RL4
        config_reg[1:0] == 2'h0
        |=> conv_ctrl_o.ref_supply && !conv_ctrl_o.ref_ext && !conv_ctrl_o.ref_fixed)
        else $error("supply reference not selected");

    AST_REF_EXT: assert property ( // RL4
        config_reg[1:0] == 2'h2
        |=> conv_ctrl_o.ref_ext && !conv_ctrl_o.ref_supply && !conv_ctrl_o.ref_fixed)
        else $error("external reference not selected");

    AST_REF_RSVD: assert property ( // RL4
        config_reg[1:0] == 2'h1
        |=> conv_ctrl_o.ref_supply && !conv_ctrl_o.ref_ext && !conv_ctrl_o.ref_fixed)
        else $error("reserved reference not on supply");

    AST_REF_ONEHOT: assert property (
        1'b1
        |=> $onehot({conv_ctrl_o.ref_supply, conv_ctrl_o.ref_ext, conv_ctrl_o.ref_fixed}))
        else $error("reference select not one hot");

    AST_RC_NO_DIV: assert property (
        conv_ctrl_o.use_rc
        |-> conv_ctrl_o.div_ratio == 7'h00)
        else $error("divider active with rc clock");

    AST_DIV_ONEHOT: assert property (
        1'b1
        |=> conv_ctrl_o.use_rc || $onehot(conv_ctrl_o.div_ratio))
        else $error("divide ratio not a single power of two");

    // ==========================================
    // checks
    AST_LEFT_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL5
        conv_result_i.valid && !config_reg[JUSTIFY_BIT] |=> result_high_reg == $past(conv_result_i.value[9:2]))
        else $error("left high mismatch");
    AST_LEFT_LOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL6
        conv_result_i.valid && !config_reg[JUSTIFY_BIT] |=> result_low_reg[7:6] == $past(conv_result_i.value[1:0]))
        else $error("left low mismatch");
    AST_LEFT_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL1
        conv_result_i.valid && !config_reg[JUSTIFY_BIT] |=> result_low_reg[5:0] == 6'h00)
        else $error("left low bits not zero");
    AST_RIGHT_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL7
        conv_result_i.valid && config_reg[JUSTIFY_BIT] |=> result_high_reg[1:0] == $past(conv_result_i.value[9:8]))
        else $error("right high mismatch");
    AST_RIGHT_PAD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL11
        conv_result_i.valid && config_reg[JUSTIFY_BIT] |=> result_high_reg[7:2] == 6'h00)
        else $error("right high pad not zero");
    AST_RIGHT_LOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL8
        conv_result_i.valid && config_reg[JUSTIFY_BIT] |=> result_low_reg == $past(conv_result_i.value[7:0]))
        else $error("right low mismatch");
    AST_CFG_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL3
        avl_req_i.read && !ack_reg && avl_req_i.address[3:2] == CONFIG_IDX |=> rdata_reg[3:2] == 2'h0)
        else $error("unimplemented bits read nonzero");
    AST_CLK_DIV64: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL12
        config_reg[6:4] == 3'h6 |=> conv_ctrl_o.div_ratio == DIV64 && !conv_ctrl_o.use_rc)
        else $error("div64 not selected");
    AST_CLK_RC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL2
        config_reg[5:4] == 2'h3 |=> conv_ctrl_o.use_rc)
        else $error("rc clock not selected");
    AST_REF_FIXED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL4
        config_reg[1:0] == 2'h3 |=> conv_ctrl_o.ref_fixed && !conv_ctrl_o.ref_supply)
        else $error("fixed reference not selected");
    AST_RES_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL10
        wr_hit && avl_req_i.address[3:2] == RES_LOW_IDX && !conv_result_i.valid
        |=> result_low_reg == $past(avl_req_i.writedata[7:0]))
        else $error("result write lost");
    AST_WAIT_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        req && !ack_reg |=> !avl_waitrequest_o)
        else $error("waitrequest too long");

    COV_LEFT: cover property (@(posedge core_clk_i) conv_result_i.valid && !config_reg[JUSTIFY_BIT]);
    COV_RIGHT: cover property (@(posedge core_clk_i) conv_result_i.valid && config_reg[JUSTIFY_BIT]);
    COV_RC: cover property (@(posedge core_clk_i) conv_ctrl_o.use_rc);
    COV_CFG_READ: cover property (@(posedge core_clk_i) avl_req_i.read && ack_reg);
    COV_REF_RSVD: cover property (@(posedge core_clk_i) config_reg[1:0] == 2'h1);
endmodule
`default_nettype wire

/* tb/adc_config_result_format_tb.sv */
`default_nettype none
module adc_config_result_format_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_cfg_pkg::*;
    // ==========================================
    // stimulus and bookkeeping
    localparam logic [6:0] div_tab [8] = '{7'h02, 7'h08, 7'h20, 7'h00, 7'h04, 7'h10, 7'h40, 7'h00};
    logic core_clk_i;
    logic rst_n_i;
    avl_req_t req;
    logic waitreq;
    logic [31:0] rdata;
    conv_result_t conv;
    conv_ctrl_t ctrl;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 94;
    int k;
    logic [7:0] d, h, w;
    logic [3:0] be = 4'hf;
    logic [9:0] v;

    adc_config_result_format dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .avl_req_i(req),
        .avl_waitrequest_o(waitreq),
        .avl_readdata_o(rdata),
        .conv_result_i(conv),
        .conv_ctrl_o(ctrl)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    function automatic conv_ctrl_t exp_ctrl(input logic [7:0] c);
        conv_ctrl_t e;
        e.use_rc = (c[5:4] == 2'h3);
        e.div_ratio = div_tab[c[6:4]];
        e.ref_supply = !c[1];
        e.ref_ext = (c[1:0] == 2'h2);
        e.ref_fixed = (c[1:0] == 2'h3);
        return e;
    endfunction

    // high byte then low byte
    function automatic logic [15:0] exp_res(input logic right, input logic [9:0] r);
        return right ? {6'h00, r} : {r, 6'h00};
    endfunction

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_ctrl(input conv_ctrl_t e, input conv_ctrl_t g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH conv_ctrl expected %h seen %h", e, g);
        end
    endtask

    // ==========================================
    // bus master: request held until waitrequest seen low
    task automatic bus(input logic rd, input logic [1:0] idx, input logic [7:0] wd);
        k = 0;
        req <= '{rd, !rd, {idx, 2'h0}, {24'h0, wd}, be};
        do begin
            @(posedge core_clk_i);
            k++;
        end while (waitreq !== 1'b0 && k < 20);
        d = rdata[7:0];
        if (k >= 20) begin
            error_cnt++;
            $display("MISMATCH waitrequest expected 0 seen 1");
            tally_and_finish;
        end
        req <= '0;
        @(posedge core_clk_i);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // hang guard, far above the several hundred cycles needed
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end

    // ==========================================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        req = '0;
        conv = '0;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // every clock and reference code; bits 3:2 always written high
        for (int c = 0; c < 32; c++) begin
            w = {1'($random(seed)), c[4:2], 2'h3, c[1:0]};
            bus(1'b0, 2'h0, w);
            bus(1'b1, 2'h0, 8'h00);
            chk("config", {8'h00, w & 8'hf3}, {8'h00, d});
            chk_ctrl(exp_ctrl(w), ctrl);
        end
        bus(1'b0, 2'h3, 8'hff);
        bus(1'b1, 2'h3, 8'h00);
        chk("unmapped", 16'h0000, {8'h00, d});
        // a write without byte lane 0 must not land
        bus(1'b0, 2'h0, 8'h00);
        be = 4'he;
        bus(1'b0, 2'h0, 8'hff);
        be = 4'hf;
        bus(1'b1, 2'h0, 8'h00);
        chk("config masked write", 16'h0000, {8'h00, d});
        // low register preset to ones so the left-mode zero fill shows
        for (int i = 0; i < 40; i++) begin
            v = (i < 2) ? {10{i[0]}} : 10'($random(seed));
            bus(1'b0, 2'h0, {i[0], 7'h00});
            bus(1'b0, 2'h2, 8'hff);
            conv <= '{1'b1, v};
            @(posedge core_clk_i);
            conv <= '0;
            bus(1'b1, 2'h1, 8'h00);
            h = d;
            bus(1'b1, 2'h2, 8'h00);
            chk("result", exp_res(i[0], v), {h, d});
        end
        // software access and survival across a reset
        bus(1'b0, 2'h0, 8'h00);
        bus(1'b0, 2'h1, 8'h5a);
        bus(1'b0, 2'h2, 8'hc3);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        bus(1'b1, 2'h1, 8'h00);
        h = d;
        bus(1'b1, 2'h2, 8'h00);
        chk("result sw", 16'h5ac3, {h, d});
        bus(1'b1, 2'h0, 8'h00);
        chk("config reset", 16'h0000, {8'h00, d});
        chk_ctrl(exp_ctrl(8'h00), ctrl);
        tally_and_finish;
    end
endmodule
`default_nettype wire
